/* File: shutdown_override_regs.vh */
// constants for the shutdown override and input select block
// assumes inclusion by bare name from the design files
`ifndef SHUTDOWN_OVERRIDE_REGS_VH
`define SHUTDOWN_OVERRIDE_REGS_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ADDR_LEVEL_SELECT   4'h0
`define ADDR_STATUS         4'h4
`define ADDR_W              4

// ----------------------------------------
// fields of level/select register
// ----------------------------------------
`define LVL_B_HI            7
`define LVL_B_LO            6
`define LVL_A_HI            5
`define LVL_A_LO            4
`define SEL_HI              1
`define SEL_LO              0
`define LEVEL_SELECT_MASK   8'hf3
`define LEVEL_SELECT_RST    8'h00

// ----------------------------------------
// override codes and input codes
// ----------------------------------------
`define LVL_HIGH            2'h3
`define LVL_LOW             2'h2
`define LVL_TRISTATE        2'h1
`define LVL_INACTIVE        2'h0
`define SRC_PWM2            2'h3
`define SRC_PWM1            2'h2
`define SRC_CMP2            2'h1
`define SRC_CMP1            2'h0

// ----------------------------------------
// dead-band default, cycles
// ----------------------------------------
`define DEADBAND_CYCLES     8'h04

`endif

/* File: override_pin_drive.v */
// one output pin drive stage under shutdown override
// assumes shutdown and resume are already resolved by the caller
`include "shutdown_override_regs.vh"

module override_pin_drive #(
  parameter DB_W = 8
) (
  input  wire            i_sys_clk,
  input  wire            i_srst,
  input  wire            i_override,
  input  wire [1:0]      i_level,
  input  wire            i_polarity,
  input  wire            i_wave,
  input  wire [DB_W-1:0] i_deadband,
  output reg             o_pin,
  output reg             o_pin_oe
);

  reg [DB_W-1:0] db_cnt_r;
  reg            db_done_r;

  // ----------------------------------------
  // dead-band timer for inactive level
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_srst || !i_override) begin
      db_cnt_r  <= {DB_W{1'b0}};
      db_done_r <= 1'b0;
    end else if (db_cnt_r >= i_deadband) begin
      db_done_r <= 1'b1;
    end else begin
      db_cnt_r <= db_cnt_r + {{(DB_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_pin    <= 1'b0;
      o_pin_oe <= 1'b0;
    end else if (!i_override) begin
      o_pin    <= i_wave ^ i_polarity;
      o_pin_oe <= 1'b1;
    end else begin
      case (i_level)
        `LVL_HIGH: begin
          o_pin    <= 1'b1;
          o_pin_oe <= 1'b1;
        end
        `LVL_LOW: begin
          o_pin    <= 1'b0;
          o_pin_oe <= 1'b1;
        end
        `LVL_TRISTATE: begin
          o_pin    <= 1'b0;
          o_pin_oe <= 1'b0;
        end
        default: begin
          // hold running level until dead-band ends, then inactive
          if (db_done_r)
            o_pin <= i_polarity;
          else
            o_pin <= i_wave ^ i_polarity;
          o_pin_oe <= 1'b1;
        end
      endcase
    end
  end

endmodule // override_pin_drive

/* File: waveform_shutdown_override.v */
// shutdown override levels and input source select with wishbone slave
// assumes shutdown flag, polarities and sources synchronous to i_sys_clk
//
// Contract
// - Override levels apply while the shutdown-active flag is set and until the post-shutdown hold clears.
// - B level 11 in shutdown drives B high regardless of B polarity.
// - B level 10 in shutdown drives B low regardless of B polarity.
// - B level 00 in shutdown drives B inactive after dead-band, polarity applied.
// - A level 11 in shutdown drives A high regardless of A polarity.
// - A level 10 in shutdown drives A low regardless of A polarity.
// - Level 01 in shutdown tri-states the corresponding output.
// - A level 00 in shutdown drives A inactive after dead-band, polarity applied.
// - Control bits 3 and 2 read zero and ignore writes.
// - After shutdown clears, overrides hold until the first input rising edge.
//
// The register offsets and register access over Wishbone are this design's own decisions.
`include "shutdown_override_regs.vh"

module waveform_shutdown_override #(
  parameter DB_W = 8
) (
  input  wire            i_sys_clk,
  input  wire            i_srst,
  input  wire            i_wb_cyc,
  input  wire            i_wb_stb,
  input  wire            i_wb_we,
  input  wire [3:0]      i_wb_adr,
  input  wire [3:0]      i_wb_sel,
  input  wire [31:0]     i_wb_dat,
  output reg  [31:0]     o_wb_dat,
  output reg             o_wb_ack,
  input  wire            i_shutdown_active_flag,
  input  wire            i_polarity_a,
  input  wire            i_polarity_b,
  input  wire [DB_W-1:0] i_deadband,
  input  wire            i_first_pwm_output,
  input  wire            i_second_pwm_output,
  input  wire            i_cmp1_async,
  input  wire            i_cmp2_async,
  output wire            o_output_a_pin,
  output wire            o_output_a_pin_oe,
  output wire            o_output_b_pin,
  output wire            o_output_b_pin_oe,
  output reg             o_override_active
);

  reg  [7:0] ctrl_r;
  reg        wave_r;
  reg        wave_prev_r;
  reg        hold_r;
  wire       wave_nxt;
  wire       wb_req;
  wire       override;

  // ----------------------------------------
  // input source select
  // ----------------------------------------
  function sel_src;
    input [1:0] code;
    input       p1, p2, c1, c2;
    begin
      case (code)
        `SRC_PWM2: sel_src = p2;
        `SRC_PWM1: sel_src = p1;
        `SRC_CMP2: sel_src = c2;
        default:   sel_src = c1;
      endcase
    end
  endfunction

  assign wave_nxt = sel_src(ctrl_r[`SEL_HI:`SEL_LO], i_first_pwm_output,
                            i_second_pwm_output, i_cmp1_async, i_cmp2_async);

  // ----------------------------------------
  // wishbone slave, one wait state
  // ----------------------------------------
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl_r   <= `LEVEL_SELECT_RST;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req) begin
        if (i_wb_we && i_wb_sel[0] && i_wb_adr == `ADDR_LEVEL_SELECT)
          ctrl_r <= i_wb_dat[7:0] & `LEVEL_SELECT_MASK;
        case (i_wb_adr)
          `ADDR_LEVEL_SELECT: o_wb_dat <= {24'h000000, ctrl_r};
          `ADDR_STATUS:       o_wb_dat <= {30'h0, hold_r, o_override_active};
          default:            o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // shutdown hold until first rising edge
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      wave_r            <= 1'b0;
      wave_prev_r       <= 1'b0;
      hold_r            <= 1'b0;
      o_override_active <= 1'b0;
    end else begin
      wave_r      <= wave_nxt;
      wave_prev_r <= wave_r;
      if (i_shutdown_active_flag)
        hold_r <= 1'b1;
      else if (wave_r && !wave_prev_r)
        hold_r <= 1'b0;
      o_override_active <= override;
    end
  end

  assign override = i_shutdown_active_flag || hold_r;

  // ----------------------------------------
  // pin stages
  // ----------------------------------------
  override_pin_drive #(.DB_W(DB_W)) u_drive_a (
    .i_sys_clk  (i_sys_clk),
    .i_srst     (i_srst),
    .i_override (override),
    .i_level    (ctrl_r[`LVL_A_HI:`LVL_A_LO]),
    .i_polarity (i_polarity_a),
    .i_wave     (wave_r),
    .i_deadband (i_deadband),
    .o_pin      (o_output_a_pin),
    .o_pin_oe   (o_output_a_pin_oe)
  );

  override_pin_drive #(.DB_W(DB_W)) u_drive_b (
    .i_sys_clk  (i_sys_clk),
    .i_srst     (i_srst),
    .i_override (override),
    .i_level    (ctrl_r[`LVL_B_HI:`LVL_B_LO]),
    .i_polarity (i_polarity_b),
    .i_wave     (~wave_r),
    .i_deadband (i_deadband),
    .o_pin      (o_output_b_pin),
    .o_pin_oe   (o_output_b_pin_oe)
  );

endmodule // waveform_shutdown_override

/* File: waveform_shutdown_override_checker.sv */
// assertions on the override block ports
// bound from the bench top file, one clock domain
module waveform_shutdown_override_checker (
  input wire        i_sys_clk, i_srst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
  input wire [3:0]  i_wb_adr, i_wb_sel,
  input wire [31:0] i_wb_dat, o_wb_dat,
  input wire        i_shutdown_active_flag,
  input wire        o_output_a_pin, o_output_a_pin_oe, o_output_b_pin, o_output_b_pin_oe
);
  reg [7:0] lvl_r;
  reg       sd_r;
  // shadow of the level/select register
  always @(posedge i_sys_clk) begin
    sd_r <= !i_srst && i_shutdown_active_flag;
    if (i_srst)
      lvl_r <= 8'h00;
    else if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_adr == 4'h0 && i_wb_sel[0])
      lvl_r <= i_wb_dat[7:0] & 8'hf3;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence sd_on;
    i_shutdown_active_flag && sd_r;
  endsequence
  ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  read_data_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 4'h0 |->
    o_wb_dat == {24'h000000, lvl_r}) else $error("read data wrong");
  b_high_a: assert property (sd_on ##0 lvl_r[7:6] == 2'h3 |=> o_output_b_pin && o_output_b_pin_oe)
    else $error("b not high");
  b_low_a: assert property (sd_on ##0 lvl_r[7:6] == 2'h2 |=> !o_output_b_pin && o_output_b_pin_oe)
    else $error("b not low");
  a_high_a: assert property (sd_on ##0 lvl_r[5:4] == 2'h3 |=> o_output_a_pin && o_output_a_pin_oe)
    else $error("a not high");
  a_low_a: assert property (sd_on ##0 lvl_r[5:4] == 2'h2 |=> !o_output_a_pin && o_output_a_pin_oe)
    else $error("a not low");
  a_float_a: assert property (sd_on ##0 lvl_r[5:4] == 2'h1 |=> !o_output_a_pin_oe) else $error("a driven");
  b_float_a: assert property (sd_on ##0 lvl_r[7:6] == 2'h1 |=> !o_output_b_pin_oe) else $error("b driven");
endmodule // waveform_shutdown_override_checker

/* File: waveform_shutdown_override_bench.sv */
// bench for the shutdown override block
// drives bus, sources and shutdown flag directly
module waveform_shutdown_override_bench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk = 1'h0, srst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, flag = 1'h0, pa = 1'h0, pb = 1'h0;
  reg  [3:0]  adr = 4'h0, sel = 4'h0, src = 4'h0;
  reg  [31:0] dat = 32'h0;
  reg  [7:0]  db = 8'h03;
  wire [31:0] rdat;
  wire        ack, a, aoe, b, boe, ovr;
  integer     miscompares = 0, num_checks = 0, i;
  waveform_shutdown_override i_waveform_shutdown_override (.i_sys_clk(clk), .i_srst(srst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_shutdown_active_flag(flag), .i_polarity_a(pa), .i_polarity_b(pb), .i_deadband(db),
    .i_cmp1_async(src[0]), .i_cmp2_async(src[1]), .i_first_pwm_output(src[2]), .i_second_pwm_output(src[3]),
    .o_output_a_pin(a), .o_output_a_pin_oe(aoe), .o_output_b_pin(b), .o_output_b_pin_oe(boe),
    .o_override_active(ovr));
  initial forever #12.5 clk = ~clk;
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task bus(input w, input [3:0] ad, input [7:0] d, input [3:0] s, output [31:0] q);
    integer k;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= ad;
    sel <= s;
    dat <= {24'h0, d};
    for (k = 0; k < 20 && ack !== 1'h1; k++) @(posedge clk);
    if (ack !== 1'h1) begin
      miscompares++;
      complete_run;
    end else begin
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
    end
  endtask
  task wr(input [3:0] ad, input [7:0] d, input [3:0] s);
    reg [31:0] q;
    bus(1'h1, ad, d, s, q);
  endtask
  task rd(input [3:0] ad, input [7:0] e);
    reg [31:0] q;
    bus(1'h0, ad, 8'h00, 4'hf, q);
    chk("read", {24'h0, e}, q);
  endtask
  // pins packed as a, a_oe, b, b_oe
  task pins(input [3:0] e, input [3:0] m);
    chk("pins", {28'h0, e & m}, {28'h0, {a, aoe, b, boe} & m});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'hff, 4'h1);
    rd(4'h0, 8'hf3);
    wr(4'h0, 8'h00, 4'h0);
    rd(4'h0, 8'hf3);
    rd(4'h8, 8'h00);
    $display("test registers done");
    for (i = 1; i < 4; i++) begin
      pa <= i[0];
      pb <= !i[0];
      wr(4'h0, {i[1:0], i[1:0], 4'h2}, 4'h1);
      flag <= 1'h1;
      repeat (4) @(posedge clk);
      pins(i == 3 ? 4'hf : (i == 2 ? 4'h5 : 4'h0), i == 1 ? 4'h5 : 4'hf);
      flag <= 1'h0;
      src <= 4'h0;
      repeat (4) @(posedge clk);
      pins(i == 3 ? 4'hf : (i == 2 ? 4'h5 : 4'h0), i == 1 ? 4'h5 : 4'hf);
      chk("override", 32'h1, {31'h0, ovr});
      rd(4'h4, 8'h03);
      src <= 4'h4;
      repeat (4) @(posedge clk);
      pins({~pa, 1'h1, pb, 1'h1}, 4'hf);
      chk("override", 32'h0, {31'h0, ovr});
      rd(4'h4, 8'h00);
    end
    $display("test override levels done");
    pa <= 1'h1;
    pb <= 1'h0;
    wr(4'h0, 8'h02, 4'h1);
    flag <= 1'h1;
    repeat (3) @(posedge clk);
    pins(4'h5, 4'hf);
    repeat (6) @(posedge clk);
    pins(4'hd, 4'hf);
    $display("test dead-band done");
    flag <= 1'h0;
    src <= 4'h0;
    pa <= 1'h0;
    for (i = 0; i < 4; i++) begin
      wr(4'h0, {6'h0, i[1:0]}, 4'h1);
      src <= 4'h1 << i;
      repeat (4) @(posedge clk);
      pins(4'hd, 4'hf);
      src <= ~(4'h1 << i);
      repeat (4) @(posedge clk);
      pins(4'h7, 4'hf);
    end
    $display("test source select done");
    complete_run;
  end
endmodule // waveform_shutdown_override_bench
bind waveform_shutdown_override waveform_shutdown_override_checker i_waveform_shutdown_override_checker (
  .i_sys_clk, .i_srst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .o_wb_ack, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
  .i_shutdown_active_flag, .o_output_a_pin, .o_output_a_pin_oe, .o_output_b_pin, .o_output_b_pin_oe);
